// [logic/bec_params.svh]
/*
 * Offsets, field positions, reset values and timing counts of the boost enable control.
 * Assumes a 200 MHz register clock and APB byte addressing with one word per register.
 */
`ifndef BEC_PARAMS_SVH
`define BEC_PARAMS_SVH

// Register indices; byte address is four times the index
`define BEC_IDX_VOUT        12'h088
`define BEC_IDX_CTRL        12'h089
`define BEC_ADDR_VOUT       (`BEC_IDX_VOUT * 4)
`define BEC_ADDR_CTRL       (`BEC_IDX_CTRL * 4)
`define BEC_ADDR_W          12

// Reset values of the two byte registers
`define BEC_VOUT_RST        8'h13
`define BEC_CTRL_RST        8'h0E

// Field positions
`define BEC_VOUT_EN_BIT     7
`define BEC_CTRL_PG_BIT     5

// Output code of the lowest step and reduced limit used in soft start
`define BEC_CODE_MIN        5'h00
`define BEC_ILIM_SOFT       2'h0

// Clock rate and times in their own units
`define BEC_CLK_MHZ         200
`define BEC_SS_ILIM_US      500
`define BEC_FSW_HI_KHZ      1000
`define BEC_FSW_LO_KHZ      500
`define BEC_DMAX_PCT        90
`define BEC_TON_MIN_NS      100
`define BEC_RAMP_STEP_US    20

// Derived cycle counts
`define BEC_SS_ILIM_CYC     (`BEC_SS_ILIM_US * `BEC_CLK_MHZ)
`define BEC_RAMP_STEP_CYC   (`BEC_RAMP_STEP_US * `BEC_CLK_MHZ)
`define BEC_PER_HI_CYC      ((`BEC_CLK_MHZ * 1000) / `BEC_FSW_HI_KHZ)
`define BEC_PER_LO_CYC      ((`BEC_CLK_MHZ * 1000) / `BEC_FSW_LO_KHZ)
`define BEC_TON_MIN_CYC     ((`BEC_TON_MIN_NS * `BEC_CLK_MHZ) / 1000)

`endif

// [logic/bec_pkg.sv]
/*
 * Types of the boost enable control: register layouts and converter states.
 * Assumes the constants header is included where numbers are needed.
 */
package bec_pkg;

    // Output voltage register layout
    typedef struct packed {
        logic       enable;      // Local enable
        logic [1:0] spare;       // Read-write spare bits
        logic [4:0] code;        // Output voltage code
    } bec_vout_s;

    // Control register layout
    typedef struct packed {
        logic [1:0] spare_hi;    // Read-write spare bits
        logic       power_good_flag; // Read-only power good
        logic       spare_mid;   // Read-write spare bit
        logic [1:0] ilim;        // Peak current limit select
        logic       clk_sel;     // 1 = high switching rate
        logic       spare_lo;    // Read-write spare bit
    } bec_ctrl_s;

    // Converter states, Gray along off, soft start, run
    typedef enum logic [1:0] {
        BEC_OFF  = 2'b00,
        BEC_SOFT = 2'b01,
        BEC_RUN  = 2'b11
    } bec_state_e;

endpackage : bec_pkg

// [logic/bec_sync.sv]
/*
 * Three-flop input synchroniser with agreement filter, one per bit.
 * Assumes inputs are asynchronous to pclk; output changes once stages two and three agree.
 */
`timescale 1ns/1ps
module bec_sync #(
    parameter int           W   = 1,
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         ce,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic s1;    // First stage, read only by s2
            logic s2;    // Second stage
            logic s3;    // Third stage

            // Shift chain; asynchronous reset to constants only
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    s1 <= RST[i];
                    s2 <= RST[i];
                    s3 <= RST[i];
                end else if (ce) begin
                    s1 <= din[i];
                    s2 <= s1;
                    s3 <= s2;
                end
            end

            // Accept a change only when stages two and three agree
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    dout[i] <= RST[i];
                end else if (ce && (s2 == s3)) begin
                    dout[i] <= s3;
                end
            end
        end
    endgenerate

endmodule : bec_sync

// [logic/bec_pwm.sv]
/*
 * Switching cycle generator with cycle-by-cycle current limit.
 * Assumes trip inputs are already synchronised to pclk.
 */
`timescale 1ns/1ps
`include "bec_params.svh"
module bec_pwm
    import bec_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic ce,
    input  wire logic run,        // Converter allowed to switch
    input  wire logic clk_sel,    // 1 = high rate, 0 = low rate
    input  wire logic ilim_trip,  // Peak current reached
    input  wire logic loop_trip,  // Regulation loop ends on-time
    output logic      gate_on,    // Low-side switch drive
    output logic      ilim_cut    // Pulse: on-time cut by limit
);

    localparam logic [8:0] TON_MIN = 9'(`BEC_TON_MIN_CYC);

    // Period in cycles for a rate select, used by both counter and duty limit
    function automatic logic [8:0] period_of(input logic sel);
        period_of = sel ? 9'(`BEC_PER_HI_CYC) : 9'(`BEC_PER_LO_CYC);
    endfunction : period_of

    // Largest on-time allowed by maximum duty
    function automatic logic [8:0] on_max_of(input logic sel);
        on_max_of = 9'((32'(period_of(sel)) * `BEC_DMAX_PCT) / 100);
    endfunction : on_max_of

    logic [8:0] cnt_reg;    // Position within the switching cycle
    logic       wrap;       // Last cycle of the period
    logic       blank_done; // Past minimum on-time, trips honoured

    assign wrap       = (cnt_reg >= period_of(clk_sel) - 9'h001);
    assign blank_done = (cnt_reg >= TON_MIN - 9'h001);

    // Period counter; restarts whenever switching is not allowed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 9'h000;
        end else if (ce) begin
            if (!run || wrap) begin
                cnt_reg <= 9'h000;
            end else begin
                cnt_reg <= cnt_reg + 9'h001;
            end
        end
    end

    // Gate drive: limit ends only the current cycle, next cycle starts afresh [R13]
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate_on  <= 1'b0;
            ilim_cut <= 1'b0;
        end else if (ce) begin
            ilim_cut <= 1'b0;
            if (!run) begin
                gate_on <= 1'b0;
            end else if (wrap) begin
                gate_on <= 1'b1;                // New cycle, limit re-armed [R13]
            end else if (gate_on && blank_done && ilim_trip) begin
                gate_on  <= 1'b0;               // Peak current reached [R13]
                ilim_cut <= 1'b1;
            end else if (gate_on && (loop_trip && blank_done
                         || cnt_reg >= on_max_of(clk_sel) - 9'h001)) begin
                gate_on <= 1'b0;
            end
        end
    end

endmodule : bec_pwm

// [logic/bec_top.sv]
/*
 * Boost enable control: APB registers, enable logic, soft start and switching control.
 * Assumes presetn is the internal power-on reset and all *_pin inputs are asynchronous.
 */
`timescale 1ns/1ps
`include "bec_params.svh"

// Operation
// R1: Run only with both enables high, no reset
// R2: Reset forces off and register defaults
// R3: Only reset reloads defaults; enables keep contents
// R4: Reset: local enable clear, code for 5.0V
// R5: Reset: 100% limit, 1 MHz clock
// R6: Software writes code with every enable change
// R7: Enable set starts soft-start ramp
// R8: Code changes accepted while running
// R9: Global enable low means lowest-power shutdown
// R10: Software raises global before local enable
// R11: Reduced peak limit first 500 us
// R12: Code writable in soft start; ramp ends there
// R13: Peak limit ends on-time each cycle
// R14: Five-bit code, 4.05 V plus 0.05 V steps
// R15: Local enable is output register bit 7
// R16: Limit codes select 25/50/75/100 percent
// R17: Clock select bit and read-only power good
module bec_top
    import bec_pkg::*;
#(
    parameter int SS_ILIM_CYC   = `BEC_SS_ILIM_CYC,   // Reduced limit window
    parameter int RAMP_STEP_CYC = `BEC_RAMP_STEP_CYC  // Cycles per ramp code step
) (
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   ce,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [`BEC_ADDR_W-1:0] paddr,
    input  wire logic [31:0]            pwdata,
    input  wire logic [3:0]             pstrb,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire logic                   global_enable_pin,
    input  wire logic                   ilim_trip_pin,
    input  wire logic                   loop_trip_pin,
    input  wire logic                   power_good_pin,
    output logic                        boost_converter_on,
    output logic                        low_power_shutdown,
    output logic                        soft_start_active,
    output logic      [4:0]             output_voltage_code,
    output logic      [1:0]             peak_current_limit_sel,
    output logic                        switch_gate,
    output logic                        ilim_cut
);

    // Register select codes for decode
    localparam logic [1:0] SEL_NONE = 2'h0;
    localparam logic [1:0] SEL_VOUT = 2'h1;
    localparam logic [1:0] SEL_CTRL = 2'h2;

    // Address decode shared by read and write paths
    function automatic logic [1:0] reg_sel(input logic [`BEC_ADDR_W-1:0] a);
        if (a == `BEC_ADDR_W'(`BEC_ADDR_VOUT)) begin
            reg_sel = SEL_VOUT;
        end else if (a == `BEC_ADDR_W'(`BEC_ADDR_CTRL)) begin
            reg_sel = SEL_CTRL;
        end else begin
            reg_sel = SEL_NONE;
        end
    endfunction : reg_sel

    bec_vout_s  vout_reg;      // Output voltage register
    bec_ctrl_s  ctrl_reg;      // Control register, status bit unused in storage
    bec_state_e state_reg;     // Converter state
    bec_state_e state_next;    // Next converter state
    logic [4:0] ramp_reg;      // Soft-start ramp code
    logic [31:0] ss_cnt_reg;   // Cycles since soft start began
    logic [31:0] step_cnt_reg; // Cycles within a ramp step
    logic       ss_ilim_done;  // Reduced limit window over
    logic       ramp_at_code;  // Ramp has reached the programmed code
    logic       run_ok;        // Both enables high
    logic       run_q;         // run_ok one cycle earlier
    logic       global_en;     // Synchronised global enable
    logic       ilim_trip;     // Synchronised peak current comparator
    logic       loop_trip;     // Synchronised loop comparator
    logic       pg_sync;       // Synchronised power good
    logic       setup;         // APB setup phase
    logic       access_wr;     // APB write completes this edge
    logic [1:0] sel;           // Decoded register
    logic [7:0] rd_byte;       // Read mux result

    // Pin synchronisers; comparators are asynchronous to pclk
    bec_sync #(
        .W   (4),
        .RST (4'h0)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .din     ({global_enable_pin, ilim_trip_pin, loop_trip_pin, power_good_pin}),
        .dout    ({global_en, ilim_trip, loop_trip, pg_sync})
    );

    // APB phase qualifiers; zero wait states, stalled only by clock enable
    assign pready    = ce;
    assign setup     = psel && !penable;
    assign access_wr = psel && penable && pwrite && ce;
    assign sel       = reg_sel(paddr);

    // Read mux; bits above the byte read as zero
    always_comb begin
        rd_byte = 8'h00;
        case (sel)
            SEL_VOUT: rd_byte = vout_reg;
            SEL_CTRL: begin
                rd_byte = ctrl_reg;
                rd_byte[`BEC_CTRL_PG_BIT] = pg_sync;      // Live status [R17]
            end
            default:  rd_byte = 8'h00;
        endcase
    end

    // Read data and error captured at setup so they come from flip-flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (ce && setup) begin
            prdata  <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
            pslverr <= (sel == SEL_NONE);
        end
    end

    // Output voltage register; only reset reloads the default [R2] [R3] [R4]
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vout_reg <= `BEC_VOUT_RST;                    // Disabled, code 5.0V [R4]
        end else if (access_wr && pstrb[0] && sel == SEL_VOUT) begin
            vout_reg <= pwdata[7:0];                      // Code and enable together [R6] [R8] [R15]
        end
    end

    // Control register; power good is not storage, it reads live
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= `BEC_CTRL_RST;                    // 100% limit, 1 MHz [R5] [R2]
        end else if (access_wr && pstrb[0] && sel == SEL_CTRL) begin
            ctrl_reg <= pwdata[7:0];                      // Limit and clock select [R16] [R17]
            ctrl_reg.power_good_flag <= 1'b0;
        end
    end

    // Both enables needed; reset holds this low through the registers [R1]
    assign run_ok = global_en && vout_reg.enable;

    // Enable edge history for starting soft start
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_q <= 1'b0;
        end else if (ce) begin
            run_q <= run_ok;
        end
    end

    assign ss_ilim_done = (ss_cnt_reg >= 32'(SS_ILIM_CYC));
    assign ramp_at_code = (ramp_reg == vout_reg.code);

    // Converter state decision
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            BEC_OFF: begin
                if (run_ok && !run_q) begin
                    state_next = BEC_SOFT;                // Enable rose, start ramp [R7]
                end
            end
            BEC_SOFT: begin
                if (!run_ok) begin
                    state_next = BEC_OFF;                 // Either enable low [R1]
                end else if (ss_ilim_done && ramp_at_code) begin
                    state_next = BEC_RUN;
                end
            end
            BEC_RUN: begin
                if (!run_ok) begin
                    state_next = BEC_OFF;                 // Either enable low [R1]
                end
            end
            default: state_next = BEC_OFF;
        endcase
    end

    // State register; reset holds the converter off [R2]
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= BEC_OFF;
        end else if (ce) begin
            state_reg <= state_next;
        end
    end

    // Reduced-limit window counter, starts at soft-start entry [R11]
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ss_cnt_reg <= 32'h0000_0000;
        end else if (ce) begin
            if (state_reg == BEC_OFF) begin
                ss_cnt_reg <= 32'h0000_0000;
            end else if (!ss_ilim_done) begin
                ss_cnt_reg <= ss_cnt_reg + 32'h0000_0001;  // Saturates at window end
            end
        end
    end

    // Ramp step timer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            step_cnt_reg <= 32'h0000_0000;
        end else if (ce) begin
            if (state_reg != BEC_SOFT || step_cnt_reg >= 32'(RAMP_STEP_CYC - 1)) begin
                step_cnt_reg <= 32'h0000_0000;
            end else begin
                step_cnt_reg <= step_cnt_reg + 32'h0000_0001;
            end
        end
    end

    // Ramp code tracks the live register code, so late writes set the end point [R12]
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ramp_reg <= `BEC_CODE_MIN;
        end else if (ce) begin
            if (state_reg != BEC_SOFT) begin
                ramp_reg <= `BEC_CODE_MIN;
            end else if (ramp_reg > vout_reg.code) begin
                ramp_reg <= vout_reg.code;                // Code lowered mid-ramp [R12]
            end else if (!ramp_at_code && step_cnt_reg >= 32'(RAMP_STEP_CYC - 1)) begin
                ramp_reg <= ramp_reg + 5'h01;             // One 50 mV step [R7] [R14]
            end
        end
    end

    // Analog-facing outputs, registered so they never glitch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            boost_converter_on     <= 1'b0;
            low_power_shutdown     <= 1'b1;
            soft_start_active      <= 1'b0;
            output_voltage_code    <= 5'(`BEC_VOUT_RST);
            peak_current_limit_sel <= `BEC_ILIM_SOFT;
        end else if (ce) begin
            boost_converter_on  <= (state_next != BEC_OFF);       // [R1]
            low_power_shutdown  <= !global_en;                    // Deepest off state [R9]
            soft_start_active   <= (state_next == BEC_SOFT);
            // Running converter follows new codes at once [R8] [R14]
            output_voltage_code <= (state_next == BEC_SOFT) ? ramp_reg : vout_reg.code;
            // Reduced limit only inside the soft-start window [R11] [R16]
            peak_current_limit_sel <= (state_next == BEC_SOFT && !ss_ilim_done)
                                      ? `BEC_ILIM_SOFT : ctrl_reg.ilim;
        end
    end

    // Switching cycle with per-cycle current limit
    bec_pwm u_pwm (
        .pclk      (pclk),
        .presetn   (presetn),
        .ce        (ce),
        .run       (boost_converter_on),
        .clk_sel   (ctrl_reg.clk_sel),
        .ilim_trip (ilim_trip),
        .loop_trip (loop_trip),
        .gate_on   (switch_gate),
        .ilim_cut  (ilim_cut)
    );

endmodule : bec_top

// [sim/bec_top_props.sv]
/* Port checker for bec_top: enable, soft start, switching and APB error relations.
   Assumes it is bound into bec_top and receives the same count parameters. */
`timescale 1ns/1ps
`include "bec_params.svh"
module bec_top_props #(
    parameter int SS_ILIM_CYC   = 50,  // Reduced limit window
    parameter int RAMP_STEP_CYC = 4    // Ramp step, kept for symmetry with the design
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        ce,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        boost_converter_on,
    input wire logic        low_power_shutdown,
    input wire logic        soft_start_active,
    input wire logic [4:0]  output_voltage_code,
    input wire logic [1:0]  peak_current_limit_sel,
    input wire logic        switch_gate,
    input wire logic        ilim_cut
);
    localparam logic [11:0] AV = 12'(`BEC_ADDR_VOUT);  // Output voltage register
    localparam logic [11:0] AC = 12'(`BEC_ADDR_CTRL);  // Control register
    int ss_cnt;                                        // Cycles spent in soft start

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Soft start age; frozen with ce so it tracks the design's own window
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) ss_cnt <= 0;
        else if (!soft_start_active) ss_cnt <= 0;
        else if (ce) ss_cnt <= ss_cnt + 1;
    end

    property p_ss_on;
        soft_start_active |-> boost_converter_on;
    endproperty
    a_ss_on: assert property (p_ss_on) else $error("soft start while off");
    property p_start;
        $rose(boost_converter_on) |-> soft_start_active && output_voltage_code == 5'h00
            && peak_current_limit_sel == 2'b00;
    endproperty
    a_start: assert property (p_start) else $error("bad start state");
    property p_window;
        soft_start_active && ss_cnt < SS_ILIM_CYC - 2 |-> peak_current_limit_sel == 2'b00;
    endproperty
    a_window: assert property (p_window) else $error("limit not reduced");
    property p_shut;
        low_power_shutdown [*3] |-> !boost_converter_on;
    endproperty
    a_shut: assert property (p_shut) else $error("on in shutdown");
    property p_off_wr;
        psel && penable && pwrite && ce && pstrb[0] && paddr == AV && !pwdata[7]
            |=> ##[0:2] !boost_converter_on;
    endproperty
    a_off_wr: assert property (p_off_wr) else $error("still on after clear");
    property p_on_wr;
        psel && penable && pwrite && ce && pstrb[0] && paddr == AV && pwdata[7]
            |=> ##[0:3] (boost_converter_on || low_power_shutdown);
    endproperty
    a_on_wr: assert property (p_on_wr) else $error("no start after set");
    property p_gate_off;
        !boost_converter_on [*3] |-> !switch_gate;
    endproperty
    a_gate_off: assert property (p_gate_off) else $error("gate while off");
    property p_cut;
        ilim_cut |-> ##[0:1] !switch_gate ##1 !ilim_cut;
    endproperty
    a_cut: assert property (p_cut) else $error("cut without gate end");
    property p_err;
        psel && penable && $past(ce) && paddr != AV && paddr != AC
            |-> pslverr && prdata == 32'h0;
    endproperty
    a_err: assert property (p_err) else $error("unmapped not refused");
endmodule : bec_top_props

bind bec_top bec_top_props #(.SS_ILIM_CYC(SS_ILIM_CYC), .RAMP_STEP_CYC(RAMP_STEP_CYC)) u_props (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pslverr(pslverr), .boost_converter_on(boost_converter_on),
    .low_power_shutdown(low_power_shutdown), .soft_start_active(soft_start_active),
    .output_voltage_code(output_voltage_code), .peak_current_limit_sel(peak_current_limit_sel),
    .switch_gate(switch_gate), .ilim_cut(ilim_cut)
);

// [sim/bec_top_bench.sv]
/* Bench for bec_top: APB registers, enables, soft start and switching.
   Assumes the design and checker compile first; counts are shortened. */
`timescale 1ns/1ps
`include "bec_params.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
    $display("MISMATCH %0t got %0h exp %0h", $time, g, e); end end
module bec_top_bench;
    localparam logic [11:0] AV = 12'(`BEC_ADDR_VOUT);
    localparam logic [11:0] AC = 12'(`BEC_ADDR_CTRL);
    logic        pclk = 1'b0;     // 200 MHz
    logic        presetn = 1'b0;  // Power-on reset
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic        glob = 1'b0;     // Global enable pin
    logic        itrip = 1'b0;    // Peak current trip pin
    logic        ltrip = 1'b0;    // Loop trip pin
    logic        pg = 1'b0;       // Power good pin
    logic [31:0] prdata, rd;
    logic        pready, pslverr, er, on, lps, ss, gate, cut;
    logic [4:0]  code;
    logic [1:0]  lim;
    int          bad_count = 0;
    int          cmp_count = 0;
    int          n;               // Cycles spent in the last wait

    // Free-running clock
    always #2.5 pclk = ~pclk;

    bec_top #(.SS_ILIM_CYC(50), .RAMP_STEP_CYC(4)) dut (
        .pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .global_enable_pin(glob),
        .ilim_trip_pin(itrip), .loop_trip_pin(ltrip), .power_good_pin(pg),
        .boost_converter_on(on), .low_power_shutdown(lps), .soft_start_active(ss),
        .output_voltage_code(code), .peak_current_limit_sel(lim), .switch_gate(gate),
        .ilim_cut(cut)
    );

    task automatic print_verdict;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : print_verdict

    task automatic hang;
        bad_count++;
        $display("Wait limit reached at %0t", $time);
        print_verdict();
    endtask : hang

    // Lets edges pass, then steps off the edge so outputs have settled
    task automatic cyc(input int k);
        repeat (k) @(posedge pclk);
        #1;
    endtask : cyc

    // One transfer; request held until pready is seen high at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 9; k++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k == 9) hang();
    endtask : apb

    task automatic rchk(input logic [11:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        `CHK({er, rd}, {1'b0, 24'h0, e})
    endtask : rchk

    // Waits for an output level: 0 on, 1 soft start, 2 gate, 3 cut
    task automatic wait_for(input int s, input logic v);
        logic x;
        for (n = 0; n < 600; n++) begin
            cyc(1);
            x = (s == 0) ? on : (s == 1) ? ss : (s == 2) ? gate : cut;
            if (x === v) break;
        end
        if (n == 600) hang();
    endtask : wait_for

    // Defaults, refused address, local enable alone
    task automatic t_reset;
        rchk(AV, 8'h13);
        rchk(AC, 8'h0E);
        `CHK({on, lps, code}, {1'b0, 1'b1, 5'h13})
        apb(1'b1, 12'h228, 8'hFF);
        `CHK({er, rd}, {1'b1, 32'h0})
        apb(1'b1, AV, 8'h93);
        cyc(20);
        `CHK(on, 1'b0)
        apb(1'b1, AV, 8'h13);
        glob <= 1'b1;
        cyc(8);
        `CHK({on, lps}, 2'b00)
    endtask : t_reset

    // Start, code change mid-ramp, change while running
    task automatic t_soft;
        apb(1'b1, AV, 8'h85);
        wait_for(0, 1'b1);
        `CHK({ss, code, lim}, {1'b1, 5'h00, 2'b00})
        apb(1'b1, AV, 8'h88);
        wait_for(1, 1'b0);
        `CHK(n > 40, 1'b1)
        `CHK({on, code, lim}, {1'b1, 5'h08, 2'b11})
        apb(1'b1, AV, 8'h91);
        cyc(3);
        `CHK({on, ss, code}, {1'b1, 1'b0, 5'h11})
    endtask : t_soft

    // One trip kind in mid on-time; the gate must end well before 90 %
    task automatic trip(input logic by_lim);
        wait_for(2, 1'b1);
        repeat (40) @(posedge pclk);
        itrip <= by_lim;
        ltrip <= !by_lim;
        wait_for(by_lim ? 3 : 2, by_lim);
        `CHK(n < 12, 1'b1)
        cyc(2);
        `CHK(gate, 1'b0)
        @(posedge pclk);
        itrip <= 1'b0;
        ltrip <= 1'b0;
    endtask : trip

    // Limit codes, both rates, trips, read-only status bit
    task automatic t_pwm;
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, AC, {4'h0, 2'(i), 2'b10});
            cyc(3);
            `CHK(lim, 2'(i))
        end
        wait_for(2, 1'b1);
        wait_for(2, 1'b0);
        `CHK(n inside {[176:181]}, 1'b1)
        apb(1'b1, AC, 8'h0C);
        wait_for(2, 1'b0);
        wait_for(2, 1'b1);
        wait_for(2, 1'b0);
        `CHK(n inside {[356:361]}, 1'b1)
        trip(1'b1);
        trip(1'b0);
        apb(1'b1, AC, 8'hEC);
        rchk(AC, 8'hCC);
        pg <= 1'b1;
        cyc(8);
        rchk(AC, 8'hEC);
    endtask : t_pwm

    // Disables keep contents; only reset reloads defaults
    task automatic t_off;
        apb(1'b1, AV, 8'h11);
        wait_for(0, 1'b0);
        `CHK(n < 4, 1'b1)
        rchk(AV, 8'h11);
        apb(1'b1, AV, 8'h91);
        wait_for(0, 1'b1);
        @(posedge pclk);
        glob <= 1'b0;
        wait_for(0, 1'b0);
        `CHK({n < 10, lps}, 2'b11)
        rchk(AV, 8'h91);
        rchk(AC, 8'hEC);
        @(posedge pclk);
        presetn <= 1'b0;
        pg <= 1'b0;
        cyc(3);
        `CHK({on, lps, code}, {1'b0, 1'b1, 5'h13})
        @(posedge pclk);
        presetn <= 1'b1;
        rchk(AV, 8'h13);
        rchk(AC, 8'h0E);
    endtask : t_off

    // Reset for ten cycles, then the scenarios in order
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_soft();
        t_pwm();
        t_off();
        print_verdict();
    end
endmodule : bec_top_bench
